//--- src/usm_device.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module usm_device
    import usm_pkg::*;
(
    // Link
    usm_link_if.device link,
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Interrupt requests and vector acknowledge
    output logic rx_done_irq,
    output logic tx_empty_irq,
    output logic tx_done_irq,
    input wire logic tx_done_vector_ack,
    // Event system
    input wire logic ir_event,
    output logic xfer_clock_event
);

    typedef struct packed {
        usm_phase_t ph;
        logic [3:0] idx;
        logic [7:0] rdata;
        usm_rx_entry_t [1:0] rxbuf;
        logic [1:0] cnt;
        logic ovf;
        logic [7:0] irq_en;
        logic [7:0] mode;
        logic [7:0] fmt;
        logic [7:0] txl;
        logic [7:0] txh;
        logic [8:0] txbuf;
        logic txfull;
        logic tx_done_f;
        logic rxsif;
        logic sync_err_f;
        logic bdf;
        logic wfb;
        logic [15:0] baud;
        logic [7:0] autobaud_window_control;
        logic [7:0] dbg;
        logic [7:0] event_input_control;
        logic [7:0] txpl;
        logic [6:0] rxpl;
        logic [15:0] xcnt;
        logic xclk;
        logic ir;
    } usm_dev_state_t;

    usm_dev_state_t q;
    usm_dev_state_t d;

    logic take;
    logic nine;
    logic low_first;
    logic tbit;
    logic accept;
    logic pop;
    logic commit;
    logic master;
    logic [8:0] cdata;
    logic [7:0] w;
    logic [7:0] status;
    logic [7:0] rxh;
    usm_rx_entry_t ent;

    assign take = hsel && htrans[1] && hready;
    assign nine = (q.fmt[2:0] == CSZ_9L) || (q.fmt[2:0] == CSZ_9H);
    assign low_first = q.fmt[2:0] == CSZ_9L;
    assign master = (q.fmt[7:6] == CMODE_SYNC) || (q.fmt[7:6] == CMODE_SPIM);
    assign w = hwdata[7:0];
    assign tbit = nine ? link.rx_frame_data[8] : link.rx_frame_stop1;
    // Address frames pass; data frames are dropped while filtering
    assign accept = link.rx_frame_valid && q.mode[B_RXEN] && !(q.mode[B_MP_FILTER] && !tbit);

    assign status = {q.cnt != 2'h0, q.tx_done_f, !q.txfull, q.rxsif, q.sync_err_f, 1'b0, q.bdf, q.wfb};
    assign rxh = {q.cnt != 2'h0, q.ovf, 3'h0, q.rxbuf[0].ferr, q.rxbuf[0].perr, q.rxbuf[0].data[8]};

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver clears unused upper bits for short characters
    always_comb begin
        cdata = link.rx_frame_data;
        unique case (q.fmt[2:0])
            CSZ_5: cdata = {4'h0, link.rx_frame_data[4:0]};
            CSZ_6: cdata = {3'h0, link.rx_frame_data[5:0]};
            CSZ_7: cdata = {2'h0, link.rx_frame_data[6:0]};
            CSZ_9L, CSZ_9H: cdata = link.rx_frame_data;
            default: cdata = {1'b0, link.rx_frame_data[7:0]};
        endcase
        ent.data = cdata;
        // With short characters in filter mode the first stop carries type, not framing
        ent.ferr = !link.rx_frame_stop1 && (nine || !q.mode[B_MP_FILTER]);
        ent.perr = link.rx_frame_perr;
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d = q;
        pop = 1'b0;
        commit = 1'b0;
        unique case (q.ph)
            PH_IDLE, PH_RDY: begin
            end
            PH_WR: begin
                unique case (q.idx)
                    IDX_TXDL: begin
                        d.txl = w;
                        commit = !q.txfull && !low_first;
                    end
                    IDX_TXDH: begin
                        d.txh = {7'h00, w[0]};
                        commit = !q.txfull && low_first;
                    end
                    IDX_STATUS: begin
                        if (w[S_TX_DONE]) d.tx_done_f = 1'b0;
                        if (w[S_RXSIF]) d.rxsif = 1'b0;
                        if (w[S_SYNC_ERR]) d.sync_err_f = 1'b0;
                        if (w[S_BDF]) d.bdf = 1'b0;
                        d.wfb = w[S_WFB];
                    end
                    IDX_IRQ_EN: d.irq_en = w;
                    IDX_MODE: d.mode = w;
                    IDX_FORMAT: d.fmt = w;
                    IDX_BAUDL: d.baud[7:0] = w;
                    IDX_BAUDH: d.baud[15:8] = w;
                    IDX_AUTOBAUD_WINDOW_CONTROL: d.autobaud_window_control = w;
                    IDX_DBG: d.dbg = w;
                    IDX_EVENT_INPUT_CONTROL: d.event_input_control = w;
                    IDX_TXPL: d.txpl = w;
                    IDX_RXPL: d.rxpl = w[6:0];
                    default: begin
                    end
                endcase
            end
            PH_RD: begin
                unique case (q.idx)
                    IDX_RXDL: d.rdata = q.rxbuf[0].data[7:0];
                    IDX_RXDH: d.rdata = rxh;
                    IDX_TXDL: d.rdata = q.txl;
                    IDX_TXDH: d.rdata = q.txh;
                    IDX_STATUS: d.rdata = status;
                    IDX_IRQ_EN: d.rdata = q.irq_en;
                    IDX_MODE: d.rdata = q.mode;
                    IDX_FORMAT: d.rdata = q.fmt;
                    IDX_BAUDL: d.rdata = q.baud[7:0];
                    IDX_BAUDH: d.rdata = q.baud[15:8];
                    IDX_AUTOBAUD_WINDOW_CONTROL: d.rdata = q.autobaud_window_control;
                    IDX_DBG: d.rdata = q.dbg;
                    IDX_EVENT_INPUT_CONTROL: d.rdata = q.event_input_control;
                    IDX_TXPL: d.rdata = q.txpl;
                    IDX_RXPL: d.rdata = {1'b0, q.rxpl};
                    default: d.rdata = REG_RST;
                endcase
                // The byte read last in the documented order advances the buffer
                pop = low_first ? (q.idx == IDX_RXDH) : (q.idx == IDX_RXDL);
            end
            default: d.ph = PH_IDLE;
        endcase

        // Bus phase sequencing; reads take one wait state so data come from a flop
        if (take) begin
            d.ph = hwrite ? PH_WR : PH_RD;
            d.idx = (haddr[31:6] == 26'h000_0000 && hsize == 3'h2) ? haddr[5:2] : IDX_NONE;
        end else if (q.ph == PH_RD) begin
            d.ph = PH_RDY;
        end else begin
            d.ph = PH_IDLE;
        end

        // Transmit buffer: writes while full are ignored
        if (commit) begin
            d.txbuf = low_first ? {w[0], q.txl} : {q.txh[0], w};
            d.txfull = 1'b1;
        end
        if (link.tx_valid && link.tx_ready) d.txfull = 1'b0;

        // Flag clears first so that a same-cycle event wins
        if (tx_done_vector_ack) d.tx_done_f = 1'b0;
        // A character still waiting at the done edge means the line is not finished
        if (link.tx_done && !q.txfull) d.tx_done_f = 1'b1;
        if (link.rx_frame_start && q.mode[B_SFDEN]) d.rxsif = 1'b1;
        if (link.rx_sync_error) d.sync_err_f = 1'b1;

        // Two-entry receive buffer, pop before push
        if (pop && q.cnt != 2'h0) begin
            d.rxbuf[0] = q.rxbuf[1];
            d.cnt = q.cnt - 2'h1;
            d.ovf = 1'b0;
        end
        if (accept) begin
            if (d.cnt == 2'h2) begin
                d.ovf = 1'b1;
            end else begin
                d.rxbuf[d.cnt[0]] = ent;
                d.cnt = d.cnt + 2'h1;
            end
        end
        if (!d.mode[B_RXEN]) begin
            d.cnt = 2'h0;
            d.ovf = 1'b0;
        end

        // Transfer clock divider; the clock toggles every divider-plus-one cycles, so every cycle for a zero divider
        if (master && q.mode[B_TXEN]) begin
            if (q.xcnt >= q.baud) begin
                d.xcnt = 16'h0000;
                d.xclk = !q.xclk;
            end else begin
                d.xcnt = q.xcnt + 16'h0001;
            end
        end else begin
            d.xcnt = 16'h0000;
            d.xclk = 1'b0;
        end

        d.ir = ir_event && q.event_input_control[EV_IR_INPUT] && (q.fmt[7:6] == CMODE_IR);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.ph <= PH_IDLE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign hreadyout = q.ph != PH_RD;
    assign hrdata = {24'h00_0000, q.rdata};
    assign hresp = 1'b0;
    assign link.tx_valid = q.txfull && q.mode[B_TXEN];
    assign link.tx_data = q.txbuf;
    assign link.ir_pulse = q.ir;
    assign xfer_clock_event = q.xclk;
    assign rx_done_irq = (q.irq_en[A_RX_DONE_EN] && q.cnt != 2'h0) || (q.irq_en[A_FRAME_START_EN] && q.rxsif) ||
                         (q.irq_en[A_AUTOBAUD_ERR_EN] && q.sync_err_f);
    assign tx_empty_irq = q.irq_en[A_TX_EMPTY_EN] && !q.txfull;
    assign tx_done_irq = q.irq_en[A_TX_DONE_EN] && q.tx_done_f;

endmodule : usm_device

//--- shared/usm_pkg.sv
// Functional notes
// - Filter bit set enters multiprocessor mode; clear leaves.
// - Five-to-eight bit frames: first stop marks type.
// - Nine-bit frames: ninth data bit marks type.
// - Type one is address, zero is data.
// - Sender uses two stops for short characters.
// - Filter on: drop data frames, keep addresses.
// - Software checks address, toggles filter around data.
// - Master modes put transfer clock out as event; here only while the transmitter is enabled.
// - Infrared event input taken as synchronous pulse.
// - Receive line ORs three enabled flag sources.
// - Empty request while enabled and buffer empty.
// - Done only when shifter idle, buffer empty.
// - Each interrupt condition sets its status flag.
// - Each source has own enable bit.
// - Request holds while flag set and enabled.
// - Two-entry receive buffer; low byte reads oldest.
// - Reading advances buffer to next character.
// - Software reads bytes in size-dependent order.
// - Receive flag tracks unread data; disable flushes.
// - Done flag clears by vector or write one.
// - Empty flag set at reset, cleared by write.
package usm_pkg;

    // Register word indexes; byte address is four times the index
    localparam logic [3:0] IDX_RXDL = 4'h0;
    localparam logic [3:0] IDX_RXDH = 4'h1;
    localparam logic [3:0] IDX_TXDL = 4'h2;
    localparam logic [3:0] IDX_TXDH = 4'h3;
    localparam logic [3:0] IDX_STATUS = 4'h4;
    localparam logic [3:0] IDX_IRQ_EN = 4'h5;
    localparam logic [3:0] IDX_MODE = 4'h6;
    localparam logic [3:0] IDX_FORMAT = 4'h7;
    localparam logic [3:0] IDX_BAUDL = 4'h8;
    localparam logic [3:0] IDX_BAUDH = 4'h9;
    localparam logic [3:0] IDX_AUTOBAUD_WINDOW_CONTROL = 4'hA;
    localparam logic [3:0] IDX_DBG = 4'hB;
    localparam logic [3:0] IDX_EVENT_INPUT_CONTROL = 4'hC;
    localparam logic [3:0] IDX_TXPL = 4'hD;
    localparam logic [3:0] IDX_RXPL = 4'hE;
    localparam logic [3:0] IDX_NONE = 4'hF;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int A_RX_DONE_EN = 7;
    localparam int A_TX_DONE_EN = 6;
    localparam int A_TX_EMPTY_EN = 5;
    localparam int A_FRAME_START_EN = 4;
    localparam int A_AUTOBAUD_ERR_EN = 2;
    localparam int B_RXEN = 7;
    localparam int B_TXEN = 6;
    localparam int B_SFDEN = 4;
    localparam int B_MP_FILTER = 0;
    localparam int S_RX_DONE = 7;
    localparam int S_TX_DONE = 6;
    localparam int S_TX_EMPTY = 5;
    localparam int S_RXSIF = 4;
    localparam int S_SYNC_ERR = 3;
    localparam int S_BDF = 1;
    localparam int S_WFB = 0;
    localparam int H_RX_DONE = 7;
    localparam int H_BUFOVF = 6;
    localparam int H_FERR = 2;
    localparam int H_PERR = 1;
    localparam int EV_IR_INPUT = 0;

    // Character size and communication mode codes
    localparam logic [2:0] CSZ_5 = 3'h0;
    localparam logic [2:0] CSZ_6 = 3'h1;
    localparam logic [2:0] CSZ_7 = 3'h2;
    localparam logic [2:0] CSZ_8 = 3'h3;
    localparam logic [2:0] CSZ_9L = 3'h6;
    localparam logic [2:0] CSZ_9H = 3'h7;
    localparam logic [1:0] CMODE_SYNC = 2'h1;
    localparam logic [1:0] CMODE_IR = 2'h2;
    localparam logic [1:0] CMODE_SPIM = 2'h3;

    // Reset values and timing
    localparam logic [7:0] REG_RST = 8'h00;
    localparam int TX_FRAME_CYCLES = 10;

    typedef struct packed {
        logic [8:0] data;
        logic ferr;
        logic perr;
    } usm_rx_entry_t;

    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_WR = 4'b0010,
        PH_RD = 4'b0100,
        PH_RDY = 4'b1000
    } usm_phase_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_START = 3'b010,
        ST_FRAME = 3'b100
    } usm_st_t;

endpackage : usm_pkg

//--- shared/usm_link_if.sv
`timescale 1ns/10ps
interface usm_link_if (
    input wire logic hclk,
    input wire logic hresetn
);
    logic rx_frame_start;
    logic rx_frame_valid;
    logic [8:0] rx_frame_data;
    logic rx_frame_stop1;
    logic rx_frame_perr;
    logic rx_sync_error;
    logic tx_valid;
    logic [8:0] tx_data;
    logic tx_ready;
    logic tx_done;
    logic ir_pulse;

    modport device (
        input rx_frame_start, rx_frame_valid, rx_frame_data, rx_frame_stop1, rx_frame_perr, rx_sync_error,
        input tx_ready, tx_done,
        output tx_valid, tx_data, ir_pulse
    );

    modport station (
        output rx_frame_start, rx_frame_valid, rx_frame_data, rx_frame_stop1, rx_frame_perr, rx_sync_error,
        output tx_ready, tx_done,
        input tx_valid, tx_data, ir_pulse
    );
endinterface : usm_link_if

//--- src/usm_station.sv
`timescale 1ns/10ps
module usm_station
    import usm_pkg::*;
(
    // Link
    usm_link_if.station link,
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Frame sending
    input wire logic nine_bit_mode,
    input wire logic send_valid,
    input wire logic send_addr,
    input wire logic [8:0] send_data,
    input wire logic send_perr,
    input wire logic sync_error_in,
    output logic send_ready,
    // Frames taken from the device
    output logic rx_valid,
    output logic [8:0] rx_data,
    output logic ir_seen
);

    typedef struct packed {
        usm_st_t st;
        logic [8:0] data;
        logic stop1;
        logic perr;
        logic sync;
        logic busy;
        logic [7:0] tcnt;
        logic [8:0] tdata;
        logic done;
        logic rxv;
        logic [8:0] rxd;
        logic ir;
    } usm_stn_state_t;

    usm_stn_state_t q;
    usm_stn_state_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.rxv = 1'b0;
        d.sync = sync_error_in;
        unique case (q.st)
            ST_IDLE: begin
                if (send_valid) begin
                    // Short characters: first stop bit is the type, second keeps framing
                    d.data = nine_bit_mode ? {send_addr, send_data[7:0]} : {1'b0, send_data[7:0]};
                    d.stop1 = nine_bit_mode ? 1'b1 : send_addr;
                    d.perr = send_perr;
                    d.st = ST_START;
                end
            end
            ST_START: d.st = ST_FRAME;
            ST_FRAME: d.st = ST_IDLE;
            default: d.st = ST_IDLE;
        endcase

        // Shift model: one character occupies a fixed number of cycles
        if (link.tx_valid && !q.busy) begin
            d.busy = 1'b1;
            d.tcnt = 8'h00;
            d.tdata = link.tx_data;
        end else if (q.busy) begin
            if (q.tcnt == 8'(TX_FRAME_CYCLES - 1)) begin
                d.busy = 1'b0;
                d.done = 1'b1;
                d.rxv = 1'b1;
                d.rxd = q.tdata;
            end else begin
                d.tcnt = q.tcnt + 8'h01;
            end
        end
        if (link.ir_pulse) d.ir = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.st <= ST_IDLE;
        end else begin
            q <= d;
        end
    end

    assign link.rx_frame_start = q.st == ST_START;
    assign link.rx_frame_valid = q.st == ST_FRAME;
    assign link.rx_frame_data = q.data;
    assign link.rx_frame_stop1 = q.stop1;
    assign link.rx_frame_perr = q.perr;
    assign link.rx_sync_error = q.sync;
    assign link.tx_ready = !q.busy;
    assign link.tx_done = q.done;
    assign send_ready = q.st == ST_IDLE;
    assign rx_valid = q.rxv;
    assign rx_data = q.rxd;
    assign ir_seen = q.ir;

endmodule : usm_station

//--- bench/usm_link_monitor.sv
`timescale 1ns/10ps
module usm_link_monitor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Receive direction
    input wire logic rx_frame_start,
    input wire logic rx_frame_valid,
    input wire logic [8:0] rx_frame_data,
    input wire logic rx_frame_stop1,
    input wire logic rx_frame_perr,
    input wire logic rx_sync_error,
    // Transmit direction
    input wire logic tx_valid,
    input wire logic [8:0] tx_data,
    input wire logic tx_ready,
    input wire logic tx_done,
    input wire logic ir_pulse
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit hand-off: one take, then a busy shifter for at least eight cycles
    sequence s_take;
        tx_valid && tx_ready;
    endsequence
    sequence s_busy;
        (!tx_ready) [*8];
    endsequence

    a_start_then_valid: assert property (rx_frame_start |=> rx_frame_valid)
        else $error("frame start not followed by frame valid");
    a_valid_needs_start: assert property (rx_frame_valid |-> $past(rx_frame_start))
        else $error("frame valid without a start one cycle before");
    a_start_one_cycle: assert property (rx_frame_start |=> !rx_frame_start)
        else $error("frame start longer than one cycle");
    a_take_busy: assert property (s_take |=> s_busy)
        else $error("shifter ready again too early after a take");
    a_take_done: assert property (s_take |-> ##[9:12] tx_done)
        else $error("frame done missing after a take");
    a_done_one_cycle: assert property (tx_done |=> !tx_done)
        else $error("frame done longer than one cycle");
    a_done_ready: assert property (tx_done |-> ##[0:1] tx_ready)
        else $error("shifter not idle after frame done");
    // A pending character must not change or vanish while the shifter is busy
    a_pending_holds: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("pending transmit data changed before it was taken");
endmodule : usm_link_monitor

//--- bench/tb_usart_multiproc_irq_regs.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_usart_multiproc_irq_regs;
    import usm_pkg::*;
    logic hclk, hresetn, hwrite, hreadyout, hresp, rx_done_irq, tx_empty_irq, tx_done_irq, tx_done_vector_ack;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic ir_event, xfer_clock_event, nine_bit_mode, send_valid, send_addr, sync_error_in;
    logic send_ready, rx_valid, ir_seen;
    logic [8:0] send_data, rx_data;
    int fail_count = 0;
    int n_tests = 0;

    usm_link_if link_bus (.hclk(hclk), .hresetn(hresetn));
    usm_device i_usm_device (.link(link_bus), .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_done_irq(rx_done_irq),
        .tx_empty_irq(tx_empty_irq), .tx_done_irq(tx_done_irq), .tx_done_vector_ack(tx_done_vector_ack),
        .ir_event(ir_event), .xfer_clock_event(xfer_clock_event));
    usm_station i_usm_station (.link(link_bus), .hclk(hclk), .hresetn(hresetn), .nine_bit_mode(nine_bit_mode),
        .send_valid(send_valid), .send_addr(send_addr), .send_data(send_data), .send_perr(1'b0),
        .sync_error_in(sync_error_in), .send_ready(send_ready), .rx_valid(rx_valid), .rx_data(rx_data),
        .ir_seen(ir_seen));
    usm_link_monitor i_usm_link_monitor (.hclk(hclk), .hresetn(hresetn),
        .rx_frame_start(link_bus.rx_frame_start), .rx_frame_valid(link_bus.rx_frame_valid),
        .rx_frame_data(link_bus.rx_frame_data), .rx_frame_stop1(link_bus.rx_frame_stop1),
        .rx_frame_perr(link_bus.rx_frame_perr), .rx_sync_error(link_bus.rx_sync_error),
        .tx_valid(link_bus.tx_valid), .tx_data(link_bus.tx_data), .tx_ready(link_bus.tx_ready),
        .tx_done(link_bus.tx_done), .ir_pulse(link_bus.ir_pulse));

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and link drivers
    task automatic ahb(input logic w, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
        @(posedge hclk);
        haddr <= {26'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata[7:0];
    endtask : ahb

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] q;
        ahb(1'b1, idx, d, q);
        // The write lands at the last edge of the call; let it settle before anyone looks
        @(posedge hclk);
    endtask : wr

    task automatic rdc(input logic [3:0] idx, input logic [7:0] exp);
        logic [7:0] q;
        ahb(1'b0, idx, 8'h00, q);
        `CHK(q, exp)
    endtask : rdc

    task automatic send(input logic a, input logic [8:0] d);
        @(posedge hclk);
        send_valid <= 1'b1;
        send_addr <= a;
        send_data <= d;
        @(posedge hclk);
        while (send_ready !== 1'b1) @(posedge hclk);
        send_valid <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : send

    // Bounded wait for the far end to report a finished frame
    task automatic expect_frame(input logic [7:0] exp);
        int i;
        @(posedge hclk);
        for (i = 0; i < 40 && rx_valid !== 1'b1; i++) @(posedge hclk);
        `CHK(rx_data[7:0], exp)
    endtask : expect_frame

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_filter;
        logic [7:0] q;
        rdc(IDX_STATUS, 8'h20);
        rdc(IDX_NONE, 8'h00);
        wr(IDX_FORMAT, 8'h03);
        wr(IDX_MODE, 8'h81);
        send(1'b0, 9'h055);
        rdc(IDX_STATUS, 8'h20);
        send(1'b1, 9'h0A3);
        rdc(IDX_STATUS, 8'hA0);
        wr(IDX_IRQ_EN, 8'h80);
        `CHK(rx_done_irq, 1'b1)
        wr(IDX_IRQ_EN, 8'h00);
        `CHK(rx_done_irq, 1'b0)
        rdc(IDX_RXDL, 8'hA3);
        wr(IDX_MODE, 8'h80);
        send(1'b0, 9'h011);
        send(1'b0, 9'h022);
        rdc(IDX_RXDL, 8'h11);
        rdc(IDX_RXDL, 8'h22);
        rdc(IDX_STATUS, 8'h20);
        nine_bit_mode <= 1'b1;
        wr(IDX_FORMAT, 8'h07);
        wr(IDX_MODE, 8'h81);
        send(1'b0, 9'h0AA);
        send(1'b1, 9'h1B4);
        ahb(1'b0, IDX_RXDH, 8'h00, q);
        `CHK(q[0], 1'b1)
        rdc(IDX_RXDL, 8'hB4);
        // Low byte first: the low byte does not advance, the high byte does
        wr(IDX_FORMAT, 8'h06);
        send(1'b1, 9'h1D6);
        rdc(IDX_RXDL, 8'hD6);
        rdc(IDX_RXDL, 8'hD6);
        ahb(1'b0, IDX_RXDH, 8'h00, q);
        `CHK(q, 8'h81)
        rdc(IDX_STATUS, 8'h20);
        send(1'b1, 9'h1C5);
        wr(IDX_MODE, 8'h00);
        rdc(IDX_STATUS, 8'h20);
        nine_bit_mode <= 1'b0;
    endtask : t_filter

    task automatic t_tx;
        wr(IDX_FORMAT, 8'h03);
        wr(IDX_IRQ_EN, 8'h60);
        `CHK(tx_empty_irq, 1'b1)
        wr(IDX_MODE, 8'h40);
        wr(IDX_TXDL, 8'h5A);
        wr(IDX_TXDL, 8'hC3);
        // Second byte waits behind the first, so neither empty nor done may show
        rdc(IDX_STATUS, 8'h00);
        expect_frame(8'h5A);
        expect_frame(8'hC3);
        rdc(IDX_STATUS, 8'h60);
        `CHK(tx_done_irq, 1'b1)
        wr(IDX_STATUS, 8'h40);
        rdc(IDX_STATUS, 8'h20);
        wr(IDX_TXDL, 8'h96);
        expect_frame(8'h96);
        repeat (2) @(posedge hclk);
        `CHK(tx_done_irq, 1'b1)
        tx_done_vector_ack <= 1'b1;
        @(posedge hclk);
        tx_done_vector_ack <= 1'b0;
        @(posedge hclk);
        `CHK(tx_done_irq, 1'b0)
        wr(IDX_IRQ_EN, 8'h00);
    endtask : t_tx

    task automatic t_events;
        logic x0;
        sync_error_in <= 1'b1;
        @(posedge hclk);
        sync_error_in <= 1'b0;
        wr(IDX_IRQ_EN, 8'h04);
        `CHK(rx_done_irq, 1'b1)
        rdc(IDX_STATUS, 8'h28);
        wr(IDX_STATUS, 8'h08);
        `CHK(rx_done_irq, 1'b0)
        wr(IDX_EVENT_INPUT_CONTROL, 8'h01);
        wr(IDX_FORMAT, 8'h80);
        ir_event <= 1'b1;
        @(posedge hclk);
        ir_event <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK(ir_seen, 1'b1)
        wr(IDX_BAUDL, 8'h01);
        wr(IDX_FORMAT, 8'h40);
        wr(IDX_MODE, 8'h40);
        @(posedge hclk);
        x0 = xfer_clock_event;
        repeat (2) @(posedge hclk);
        `CHK(xfer_clock_event, ~x0)
    endtask : t_events

    task automatic wrap_up;
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Whole run is a few hundred cycles; this limit only catches a hang
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        wrap_up();
    end

    initial begin
        hresetn = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0000_0000;
        tx_done_vector_ack = 1'b0;
        ir_event = 1'b0;
        nine_bit_mode = 1'b0;
        send_valid = 1'b0;
        send_addr = 1'b0;
        send_data = 9'h000;
        sync_error_in = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_filter();
        t_tx();
        t_events();
        wrap_up();
    end
endmodule : tb_usart_multiproc_irq_regs
